/* src/pbp_bus_seq.v */
// External access sequencer: address phase, data phase and byte splitting.
`timescale 1ns/1ns
`include "pbp_defines.vh"

module pbp_bus_seq #(
	parameter PHASE = `PBP_PHASE_CYC
) (
	// Clock and reset.
	input wire aclk,
	input wire aresetn,
	// Access request.
	input wire start,
	input wire write,
	input wire word,
	input wire mux,
	input wire w16,
	input wire [15:0] addr,
	input wire [15:0] wdata,
	// Port line levels.
	input wire [15:0] pad_in,
	// Drive request and access answer.
	output reg [15:0] oe,
	output reg [15:0] val,
	output reg busy,
	output reg done,
	output reg [15:0] rdata
);

	localparam ST_IDLE = 2'd0;
	localparam ST_ADDR = 2'd1;
	localparam ST_DATA = 2'd2;

	reg [1:0] state;
	reg [7:0] cnt;
	reg hi, wr, wd, mx, wide;
	reg [15:0] a, d;
	wire last = (cnt == PHASE - 1);

	// Lane drive per phase; a read data phase leaves every line released.
	always @* begin
		oe = 16'h0000;
		val = 16'h0000;
		if (state == ST_ADDR) begin
			oe = 16'hFFFF;
			val = a | {15'h0000, hi};
		end else if (state == ST_DATA && wr) begin
			oe = wide ? 16'hFFFF : 16'h00FF;
			val = wide ? d : {8'h00, hi ? d[15:8] : d[7:0]};
		end
	end

	// Phase sequence; an 8-bit word access repeats the cycle for the high byte.
	always @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_IDLE;
			cnt <= 8'h00;
			hi <= 1'b0;
			{wr, wd, mx, wide} <= 4'h0;
			a <= 16'h0000;
			d <= 16'h0000;
			busy <= 1'b0;
			done <= 1'b0;
			rdata <= 16'h0000;
		end else begin
			done <= 1'b0;
			cnt <= last ? 8'h00 : cnt + 8'h01;
			case (state)
				ST_IDLE: begin
					cnt <= 8'h00;
					if (start) begin
						{wr, wd, mx, wide} <= {write, word, mux, w16};
						a <= addr;
						d <= wdata;
						hi <= 1'b0;
						busy <= 1'b1;
						state <= mux ? ST_ADDR : ST_DATA;
					end
				end
				ST_ADDR: if (last) state <= ST_DATA;
				ST_DATA: if (last) begin
					if (!wr && wide) rdata <= pad_in;
					if (!wr && !wide && !hi) rdata[7:0] <= pad_in[7:0];
					if (!wr && !wide && hi) rdata[15:8] <= pad_in[7:0];
					if (!wide && wd && !hi) begin
						hi <= 1'b1;
						state <= mx ? ST_ADDR : ST_DATA;
					end else begin
						busy <= 1'b0;
						done <= 1'b1;
						state <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

endmodule // pbp_bus_seq

/* src/pbp_defines.vh */
// Register map, field positions, reset values and timing counts of the bus port.
`ifndef PBP_DEFINES_VH
`define PBP_DEFINES_VH

// ************************************************************
// Register word indices (byte address is four times the index)
// ************************************************************
`define PBP_IDX_PD_LOW 16'hFE68
`define PBP_IDX_PD_HIGH 16'hFE6A
`define PBP_ADDR_PD_LOW {`PBP_IDX_PD_LOW, 2'b00}
`define PBP_ADDR_PD_HIGH {`PBP_IDX_PD_HIGH, 2'b00}

// ************************************************************
// Byte addresses of the port control registers
// ************************************************************
`define PBP_ADDR_LATCH 18'h0_0000
`define PBP_ADDR_DIR 18'h0_0004
`define PBP_ADDR_PULL_EN 18'h0_0008
`define PBP_ADDR_PULL_SEL 18'h0_000C
`define PBP_ADDR_BUSCFG 18'h0_0010
`define PBP_ADDR_STARTUP 18'h0_0014
`define PBP_ADDR_PINS 18'h0_0018
`define PBP_ADDR_STATUS 18'h0_001C

// ************************************************************
// Reset values
// ************************************************************
`define PBP_RST_PD 8'h00
`define PBP_RST_PULL 16'hFFFF
`define PBP_RST_LATCH 16'h0000
`define PBP_RST_DIR 16'h0000
`define PBP_RST_BUSCFG 8'hFF

// ************************************************************
// Bus configuration fields
// ************************************************************
`define PBP_CFG_EN_BIT 5
`define PBP_CFG_MUX_BIT 6
`define PBP_CFG_W16_BIT 7

// ************************************************************
// Bus answers and timing
// ************************************************************
`define PBP_RESP_OKAY 2'b00
`define PBP_RESP_SLVERR 2'b10
`define PBP_PHASE_NS 40
`define PBP_CLK_NS 20
`define PBP_PHASE_CYC (`PBP_PHASE_NS / `PBP_CLK_NS)

`endif

/* src/pbp_port.v */
// Sixteen-line bus port with startup capture, power-down drive and register slave.
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ns
`include "pbp_defines.vh"

module pbp_port #(
	parameter AW = 18,
	parameter PHASE = `PBP_PHASE_CYC
) (
	// Clock and reset.
	input wire aclk,
	input wire aresetn,
	// AXI4-Lite write address and data.
	input wire [AW-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// AXI4-Lite write response.
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read.
	input wire [AW-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Port lines.
	input wire [15:0] pad_in,
	output reg [15:0] pad_out,
	output reg [15:0] pad_oe,
	output reg [15:0] pad_pull_en,
	output reg [15:0] pad_pull_sel,
	// System power-down level.
	input wire powerdown,
	// External access request from the bus controller.
	input wire acc_req,
	input wire acc_write,
	input wire acc_word,
	input wire [15:0] acc_addr,
	input wire [15:0] acc_wdata,
	// External access answer.
	output reg acc_busy,
	output reg acc_done,
	output reg [15:0] acc_rdata,
	output reg [15:0] alt_in
);

	// ************************************************************
	// Registers and internal nets
	// ************************************************************
	reg [7:0] low_byte_powerdown_drive;
	reg [7:0] high_byte_powerdown_drive;
	reg [15:0] bus_port_latch;
	reg [15:0] dir;
	reg [15:0] pull_enable_bit;
	reg [15:0] pull_select_bit;
	reg [7:0] first_window_bus_config;
	reg [7:0] startup_high_byte_capture;
	reg [AW-1:0] wr_addr;
	reg [31:0] wr_data;
	reg [3:0] wr_strb;
	reg [31:0] rd_word;
	reg rd_hit;
	reg wr_hit;
	reg [15:0] bus_lanes;
	reg [15:0] next_oe;
	reg [15:0] next_out;

	wire [15:0] strap;
	wire strap_load;
	wire [15:0] seq_oe;
	wire [15:0] seq_val;
	wire seq_busy;
	wire seq_done;
	wire [15:0] seq_rdata;
	wire bus_on = first_window_bus_config[`PBP_CFG_EN_BIT];
	wire bus_mux = first_window_bus_config[`PBP_CFG_MUX_BIT];
	wire bus_w16 = first_window_bus_config[`PBP_CFG_W16_BIT];
	wire [15:0] pd_drive = {high_byte_powerdown_drive, low_byte_powerdown_drive};
	wire acc_start = acc_req & bus_on & ~seq_busy;

	// Byte-lane merge of a 16-bit register with a write word.
	function [15:0] merge16;
		input [15:0] old;
		input [31:0] data;
		input [3:0] strb;
		begin
			merge16 = old;
			if (strb[0])
				merge16[7:0] = data[7:0];
			if (strb[1])
				merge16[15:8] = data[15:8];
		end
	endfunction

	// ************************************************************
	// Startup capture and access sequencer
	// ************************************************************

	// The line levels present during reset become the startup configuration.
	pbp_strap u_strap (
		.aclk(aclk),
		.aresetn(aresetn),
		.pad_in(pad_in),
		.strap(strap),
		.load(strap_load)
	);

	// Address phase (multiplexed bus only) and data phase of each external access.
	pbp_bus_seq #(
		.PHASE(PHASE)
	) u_seq (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(acc_start),
		.write(acc_write),
		.word(acc_word),
		.mux(bus_mux),
		.w16(bus_w16),
		.addr(acc_addr),
		.wdata(acc_wdata),
		.pad_in(pad_in),
		.oe(seq_oe),
		.val(seq_val),
		.busy(seq_busy),
		.done(seq_done),
		.rdata(seq_rdata)
	);

	// ************************************************************
	// Pin direction and output selection
	// ************************************************************

	// Lines claimed by the bus; the high byte stays general I/O on an 8-bit demux bus.
	always @* begin
		if (!bus_on)
			bus_lanes = 16'h0000;
		else if (!bus_mux && !bus_w16)
			bus_lanes = 16'h00FF;
		else
			bus_lanes = 16'hFFFF;
	end

	// Claimed lines follow the sequencer, the rest follow the user registers.
	always @* begin
		next_oe = (bus_lanes & seq_oe) | (~bus_lanes & dir);
		next_out = (bus_lanes & seq_val) | (~bus_lanes & bus_port_latch);
		if (powerdown)
			next_oe = next_oe & pd_drive;
	end

	// Pad drivers are registered; pulls are dropped on any line being driven.
	always @(posedge aclk) begin
		if (!aresetn) begin
			pad_oe <= 16'h0000;
			pad_out <= 16'h0000;
			pad_pull_en <= `PBP_RST_PULL;
			pad_pull_sel <= `PBP_RST_PULL;
			alt_in <= 16'h0000;
		end else begin
			pad_oe <= next_oe;
			pad_out <= next_out;
			pad_pull_en <= pull_enable_bit & ~next_oe;
			pad_pull_sel <= pull_select_bit;
			alt_in <= pad_in & bus_lanes;
		end
	end

	// Access answer registered once more so every output leaves a flip-flop.
	always @(posedge aclk) begin
		if (!aresetn) begin
			acc_busy <= 1'b0;
			acc_done <= 1'b0;
			acc_rdata <= 16'h0000;
		end else begin
			acc_busy <= seq_busy | acc_start;
			acc_done <= seq_done;
			acc_rdata <= seq_rdata;
		end
	end

	// ************************************************************
	// AXI4-Lite write channel
	// ************************************************************

	// Known addresses for writes; the read-only ones answer with an error.
	always @* begin
		case (wr_addr)
			`PBP_ADDR_PD_LOW, `PBP_ADDR_PD_HIGH, `PBP_ADDR_LATCH, `PBP_ADDR_DIR,
			`PBP_ADDR_PULL_EN, `PBP_ADDR_PULL_SEL, `PBP_ADDR_BUSCFG: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// Address and data are taken in either order; the response follows both.
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `PBP_RESP_OKAY;
			wr_addr <= {AW{1'b0}};
			wr_data <= 32'h0000_0000;
			wr_strb <= 4'h0;
			low_byte_powerdown_drive <= `PBP_RST_PD;
			high_byte_powerdown_drive <= `PBP_RST_PD;
			bus_port_latch <= `PBP_RST_LATCH;
			dir <= `PBP_RST_DIR;
			pull_enable_bit <= `PBP_RST_PULL;
			pull_select_bit <= `PBP_RST_PULL;
			first_window_bus_config <= `PBP_RST_BUSCFG;
			startup_high_byte_capture <= `PBP_RST_BUSCFG;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				wr_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wr_data <= s_axi_wdata;
				wr_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? `PBP_RESP_OKAY : `PBP_RESP_SLVERR;
				case (wr_addr)
					`PBP_ADDR_PD_LOW: if (wr_strb[0])
						low_byte_powerdown_drive <= wr_data[7:0];
					`PBP_ADDR_PD_HIGH: if (wr_strb[0])
						high_byte_powerdown_drive <= wr_data[7:0];
					// Written even in bus mode; the bus-claimed pins then ignore it.
					`PBP_ADDR_LATCH: bus_port_latch <= merge16(bus_port_latch, wr_data, wr_strb);
					`PBP_ADDR_DIR: dir <= merge16(dir, wr_data, wr_strb);
					`PBP_ADDR_PULL_EN:
						pull_enable_bit <= merge16(pull_enable_bit, wr_data, wr_strb);
					`PBP_ADDR_PULL_SEL:
						pull_select_bit <= merge16(pull_select_bit, wr_data, wr_strb);
					`PBP_ADDR_BUSCFG: if (wr_strb[0])
						first_window_bus_config <= wr_data[7:0];
					default: begin
					end
				endcase
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
			// The startup load pulses in the second cycle after reset and wins.
			if (strap_load) begin
				first_window_bus_config <= strap[7:0];
				startup_high_byte_capture <= strap[15:8];
			end
		end
	end

	// ************************************************************
	// AXI4-Lite read channel
	// ************************************************************

	// Read word selection; upper bits of every register read as zero.
	always @* begin
		rd_hit = 1'b1;
		rd_word = 32'h0000_0000;
		case (s_axi_araddr)
			`PBP_ADDR_PD_LOW: rd_word[7:0] = low_byte_powerdown_drive;
			`PBP_ADDR_PD_HIGH: rd_word[7:0] = high_byte_powerdown_drive;
			`PBP_ADDR_LATCH: rd_word[15:0] = bus_port_latch;
			`PBP_ADDR_DIR: rd_word[15:0] = dir;
			`PBP_ADDR_PULL_EN: rd_word[15:0] = pull_enable_bit;
			`PBP_ADDR_PULL_SEL: rd_word[15:0] = pull_select_bit;
			`PBP_ADDR_BUSCFG: rd_word[7:0] = first_window_bus_config;
			`PBP_ADDR_STARTUP: rd_word[7:0] = startup_high_byte_capture;
			`PBP_ADDR_PINS: rd_word[15:0] = pad_in;
			`PBP_ADDR_STATUS: rd_word[0] = seq_busy;
			default: rd_hit = 1'b0;
		endcase
	end

	// One read at a time; the answer comes one cycle after the address is taken.
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `PBP_RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_hit ? `PBP_RESP_OKAY : `PBP_RESP_SLVERR;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule // pbp_port

/* src/pbp_strap.v */
// Startup configuration capture from the port lines during reset.
`timescale 1ns/1ns
`include "pbp_defines.vh"

module pbp_strap (
	// Clock and reset.
	input wire aclk,
	input wire aresetn,
	// Port line levels.
	input wire [15:0] pad_in,
	// Captured configuration and its load pulse.
	output reg [15:0] strap,
	output reg load
);

	reg armed;

	// Lines are sampled every reset cycle, so the last level before release is kept.
	always @(posedge aclk) begin
		if (!aresetn) begin
			strap <= pad_in;
			armed <= 1'b1;
			load <= 1'b0;
		end else begin
			load <= armed;
			armed <= 1'b0;
		end
	end

endmodule // pbp_strap

/* verification/pbp_ext_mem.sv */
// Behavioural external memory and line levels around the bus port.
`timescale 1ns/1ns

module pbp_ext_mem (
	// Clock.
	input wire aclk,
	// Lines as the port drives them.
	input wire [15:0] pad_out,
	input wire [15:0] pad_oe,
	input wire [15:0] pull_en,
	input wire [15:0] pull_sel,
	// Board pull-downs and read answer enable.
	input wire [15:0] ext_pd,
	input wire respond,
	// Line levels and what the memory saw.
	output reg [15:0] pad_in,
	output reg [15:0] last_addr = 16'h0000,
	output reg [15:0] last_data = 16'h0000
);
	// ****
	// Lines
	// ****
	reg [15:0] prev = 16'h0000;
	reg [7:0] oe_q = 8'h00;
	reg [15:0] lvl;

	// Board pull-downs beat the weak pull-ups; a floating line flips, so no stale level survives.
	always @* begin
		lvl = (pull_en & pull_sel) | (~pull_en & ~prev);
		lvl = lvl & ~ext_pd;
		if (respond) begin
			lvl = last_addr ^ 16'hC3C3;
		end
		pad_in = (pad_oe & pad_out) | (~pad_oe & lvl);
	end

	// The first driven cycle of a low byte carries the address, the last one the data.
	always @(posedge aclk) begin
		prev <= pad_in;
		oe_q <= pad_oe[7:0];
		if (pad_oe[7:0] != 8'h00 && oe_q == 8'h00) begin
			last_addr <= pad_out;
		end
		if (pad_oe[7:0] != 8'h00) begin
			last_data <= pad_out;
		end
	end
endmodule // pbp_ext_mem

/* verification/pbp_port_chk.sv */
// Concurrent checks on the bus port's pins and register bus.
`timescale 1ns/1ns

module pbp_port_chk (
	// Clock and reset.
	input wire aclk,
	input wire aresetn,
	// Register bus.
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	// Lines and external access.
	input wire [15:0] pad_oe,
	input wire [15:0] pad_pull_en,
	input wire [15:0] pad_pull_sel,
	input wire acc_write,
	input wire acc_busy,
	input wire acc_done
);
	// ****
	// Checks
	// ****
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire [7:0] oe_lo = pad_oe[7:0];

	// A read taken, and the answer one cycle on.
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_rd_answer;
		s_axi_rvalid && !s_axi_arready;
	endsequence

	AST_RESET_PINS: assert property (disable iff (1'b0) !aresetn |=>
		pad_oe == 16'h0000 && pad_pull_en == 16'hFFFF && pad_pull_sel == 16'hFFFF)
		else $error("lines not inputs with pull-ups in reset");
	AST_RD_ANSWER: assert property (s_rd_take |=> s_rd_answer)
		else $error("read answer late");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	AST_BUSY_ENDS: assert property ($rose(acc_busy) |-> ##[1:24] acc_done)
		else $error("access never done");
	AST_DONE_ONE: assert property (acc_done |=> !acc_done)
		else $error("done longer than a cycle");
	AST_READ_RELEASE: assert property (acc_done && !acc_write |-> $past(oe_lo) == 8'h00)
		else $error("read lines still driven");
	AST_WRITE_DRIVE: assert property (acc_done && acc_write |-> $past(oe_lo, 2) == 8'hFF)
		else $error("write data not driven");
endmodule // pbp_port_chk

bind pbp_port pbp_port_chk i_pbp_port_chk (
	.aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .pad_oe(pad_oe), .pad_pull_en(pad_pull_en),
	.pad_pull_sel(pad_pull_sel), .acc_write(acc_write), .acc_busy(acc_busy),
	.acc_done(acc_done)
);

/* verification/pbp_port_tb.sv */
// Self-checking bench for the bus port.
`timescale 1ns/1ns
`include "pbp_defines.vh"

module pbp_port_tb;
	// ****
	// Signals
	// ****
	reg aclk = 1'b0;
	reg aresetn = 1'b0;
	reg [17:0] awaddr = 18'h0_0000;
	reg [17:0] araddr = 18'h0_0000;
	reg [31:0] wdata = 32'h0000_0000;
	reg awvalid = 1'b0;
	reg wvalid = 1'b0;
	reg bready = 1'b0;
	reg arvalid = 1'b0;
	reg rready = 1'b0;
	reg powerdown = 1'b0;
	reg acc_req = 1'b0;
	reg acc_write = 1'b0;
	reg acc_word = 1'b0;
	reg [15:0] acc_addr = 16'h0000;
	reg [15:0] acc_wdata = 16'h0000;
	reg respond = 1'b0;
	reg dn = 1'b0;
	wire awready, wready, bvalid, arready, rvalid, acc_busy, acc_done;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [15:0] pad_in, pad_out, pad_oe, pull_en, pull_sel, acc_rdata, last_addr, last_data;
	wire [15:0] alt_in;
	integer fails = 0;
	integer n_tests = 0;
	integer cyc = 0;

	pbp_port i_pbp_port (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'h3), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
		.pad_pull_en(pull_en), .pad_pull_sel(pull_sel), .powerdown(powerdown),
		.acc_req(acc_req), .acc_write(acc_write), .acc_word(acc_word),
		.acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_busy(acc_busy),
		.acc_done(acc_done), .acc_rdata(acc_rdata), .alt_in(alt_in)
	);

	// Board pull-downs on lines 14,12,11,9 and 0 give a startup value of A5FE.
	pbp_ext_mem i_pbp_ext_mem (
		.aclk(aclk), .pad_out(pad_out), .pad_oe(pad_oe), .pull_en(pull_en),
		.pull_sel(pull_sel), .ext_pd(16'h5A01), .respond(respond),
		.pad_in(pad_in), .last_addr(last_addr), .last_data(last_data)
	);

	// 50 MHz clock.
	always #10 aclk = ~aclk;

	// ****
	// Tasks
	// ****
	task chk(input [31:0] got, input [31:0] exp);
		begin
			n_tests = n_tests + 1;
			if (got !== exp) begin
				fails = fails + 1;
				$display("mismatch at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask

	// Address and data go up together; each drops once taken, bready waits for the answer.
	task wr(input [17:0] a, input [31:0] d, input [1:0] er);
		begin
			@(posedge aclk);
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			do begin
				@(posedge aclk);
				if (awready) awvalid <= 1'b0;
				if (wready) wvalid <= 1'b0;
			end while (!bvalid);
			bready <= 1'b0;
			chk(bresp, er);
		end
	endtask

	task rd(input [17:0] a, input [31:0] e, input [1:0] er);
		begin
			@(posedge aclk);
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
			do begin
				@(posedge aclk);
				if (arready) arvalid <= 1'b0;
			end while (!rvalid);
			rready <= 1'b0;
			chk(rdata, e);
			chk(rresp, er);
		end
	endtask

	// Request fields stay put until the next access so the checker can see them.
	task acc(input w, input wd, input [15:0] a, input [15:0] d);
		begin
			@(posedge aclk);
			acc_req <= 1'b1;
			acc_write <= w;
			acc_word <= wd;
			acc_addr <= a;
			acc_wdata <= d;
			@(posedge aclk);
			acc_req <= 1'b0;
			do @(posedge aclk); while (!acc_done);
		end
	endtask

	task end_sim;
		begin
			$display("comparisons %0d mismatches %0d", n_tests, fails);
			if (fails == 0 && n_tests > 0) begin
				$display("Simulation passed");
			end else begin
				$display("Simulation failed");
			end
			$finish;
		end
	endtask

	// A hang is cut off well past the roughly 150 cycles the tests need.
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fails = fails + 1;
			end_sim;
		end
	end

	// ****
	// Tests
	// ****
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		respond <= 1'b1;
		chk(pull_en, 16'hFFFF);
		rd(`PBP_ADDR_BUSCFG, 32'h0000_00FE, `PBP_RESP_OKAY);
		rd(`PBP_ADDR_STARTUP, 32'h0000_00A5, `PBP_RESP_OKAY);
		rd(`PBP_ADDR_PULL_SEL, 32'h0000_FFFF, `PBP_RESP_OKAY);
		rd(`PBP_ADDR_PD_LOW, 32'h0000_0000, `PBP_RESP_OKAY);
		rd(`PBP_ADDR_PD_HIGH, 32'h0000_0000, `PBP_RESP_OKAY);
		rd(18'h0_0020, 32'h0000_0000, `PBP_RESP_SLVERR);
		wr(`PBP_ADDR_STARTUP, 32'h0000_0000, `PBP_RESP_SLVERR);
		wr(`PBP_ADDR_PULL_EN, 32'h0000_0000, `PBP_RESP_OKAY);
		wr(`PBP_ADDR_DIR, 32'h0000_FFFF, `PBP_RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk(pull_en, 16'h0000);
		chk(pad_oe, 16'h0000);
		// 16-bit multiplexed read and write.
		acc(1'b0, 1'b0, 16'h1234, 16'h0000);
		chk(acc_rdata, 16'hD1F7);
		chk(last_addr, 16'h1234);
		acc(1'b1, 1'b0, 16'h0ABC, 16'h5E71);
		chk(last_addr, 16'h0ABC);
		chk(last_data, 16'h5E71);
		// 8-bit multiplexed word accesses.
		wr(`PBP_ADDR_BUSCFG, 32'h0000_0060, `PBP_RESP_OKAY);
		acc(1'b1, 1'b1, 16'h0100, 16'h9A3C);
		chk(last_data[7:0], 8'h9A);
		acc(1'b0, 1'b1, 16'h0200, 16'h0000);
		chk(acc_rdata, 16'hC2C3);
		// Bus off: the direction register and latch own the lines.
		wr(`PBP_ADDR_BUSCFG, 32'h0000_0000, `PBP_RESP_OKAY);
		wr(`PBP_ADDR_LATCH, 32'h0000_A534, `PBP_RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk(pad_oe, 16'hFFFF);
		chk(pad_out, 16'hA534);
		acc_req <= 1'b1;
		repeat (20) begin
			@(posedge aclk);
			dn = dn | acc_done;
		end
		acc_req <= 1'b0;
		chk(dn, 1'b0);
		wr(`PBP_ADDR_PD_LOW, 32'h0000_000F, `PBP_RESP_OKAY);
		wr(`PBP_ADDR_PD_HIGH, 32'h0000_0080, `PBP_RESP_OKAY);
		powerdown <= 1'b1;
		repeat (3) @(posedge aclk);
		chk(pad_oe, 16'h800F);
		powerdown <= 1'b0;
		rd(`PBP_ADDR_PD_HIGH, 32'h0000_0080, `PBP_RESP_OKAY);
		// 8-bit demultiplexed: high byte stays user I/O.
		wr(`PBP_ADDR_DIR, 32'h0000_FF00, `PBP_RESP_OKAY);
		wr(`PBP_ADDR_BUSCFG, 32'h0000_0020, `PBP_RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk(pad_oe, 16'hFF00);
		chk(pad_out[15:8], 8'hA5);
		acc(1'b1, 1'b0, 16'h0300, 16'h0077);
		chk(last_addr[7:0], 8'h77);
		// Released low lines carry the memory's answer; the user-owned high byte is masked off.
		repeat (2) @(posedge aclk);
		chk(alt_in, {8'h00, last_addr[7:0] ^ 8'hC3});
		end_sim;
	end
endmodule // pbp_port_tb
